// *** ccr_pkg.sv ***
// package: offsets, field positions, reset values and types of the card configuration registers
package ccr_pkg;

   // ---------------------------------------------
   // attribute offsets
   // ---------------------------------------------
   localparam logic [10:0] CCR_BASE_ADDR        = 11'h200;
   localparam logic [10:0] CCR_OPTION_ADDR      = 11'h200;
   localparam logic [10:0] CCR_STATUS_ADDR      = 11'h202;
   localparam logic [10:0] CCR_PINREP_ADDR      = 11'h204;
   localparam logic [10:0] CCR_SOCKET_ADDR      = 11'h206;

   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int CCR_OPT_SOFT_RST_BIT = 7;
   localparam int CCR_OPT_LEVIRQ_BIT  = 6;
   localparam int CCR_STS_CHANGED_BIT = 7;
   localparam int CCR_STS_CHG_EN_BIT  = 6;
   localparam int CCR_STS_IO8_BIT     = 5;
   localparam int CCR_STS_PWRDN_BIT   = 2;
   localparam int CCR_STS_INT_BIT     = 1;
   localparam int CCR_PIN_CRDY_BIT    = 5;
   localparam int CCR_PIN_CWP_BIT     = 4;
   localparam int CCR_PIN_RRDY_BIT    = 1;
   localparam int CCR_PIN_WP_BIT      = 0;
   localparam int CCR_SCK_DRIVE_BIT   = 4;

   // ---------------------------------------------
   // reset values and encodings
   // ---------------------------------------------
   localparam logic [7:0] CCR_OPTION_RESET  = 8'h00;
   localparam logic [7:0] CCR_STATUS_RESET  = 8'h00;
   localparam logic [7:0] CCR_SOCKET_RESET  = 8'h00;
   localparam logic [7:0] CCR_PINREP_FIXED  = 8'h0C;
   localparam logic [5:0] CCR_IDX_MEMORY    = 6'h00;
   localparam logic [5:0] CCR_IDX_CONTIG    = 6'h01;
   localparam logic [5:0] CCR_IDX_PRIMARY   = 6'h02;
   localparam logic [5:0] CCR_IDX_SECONDARY = 6'h03;
   localparam logic [9:0] CCR_PRI_BLK_ADDR  = 10'h1F0;
   localparam logic [9:0] CCR_PRI_CTL_ADDR  = 10'h3F6;
   localparam logic [9:0] CCR_SEC_BLK_ADDR  = 10'h170;
   localparam logic [9:0] CCR_SEC_CTL_ADDR  = 10'h376;
   localparam logic [10:0] CCR_MIRROR_ADDR  = 11'h400;

   // power transition time in cycles until ready returns
   localparam int CCR_PWR_SETTLE_CYCLES = 16;

   // host-side strobes of the attribute bus, all active low
   typedef struct packed {
      logic        reg_n;
      logic        ce1_n;
      logic        ce2_n;
      logic        oe_n;
      logic        we_n;
      logic [10:0] addr;
   } ccr_bus_t;

   typedef enum logic [2:0] {
      CCR_MAP_MEMORY    = 3'b001,
      CCR_MAP_IO        = 3'b010,
      CCR_MAP_NONE      = 3'b100
   } ccr_map_t;

   typedef enum logic [2:0] {
      CCR_PWR_ACTIVE = 3'b001,
      CCR_PWR_MOVING = 3'b010,
      CCR_PWR_SAVING = 3'b100
   } ccr_pwr_t;

endpackage

// *** ccr_regs.sv ***
// card configuration register bank in attribute memory
`timescale 1ns/100ps
// Operation
// - config registers at attribute 200h, even, selected
// - decode option, status, pin replacement, socket registers
// - odd or CIS-write accesses have no effect
// - option: soft reset, level select, index
// - soft reset holds card reset, unconfigured
// - soft reset cleared at power-up, hardware reset
// - level select chooses level or pulse interrupt
// - index 0 memory, 1 contiguous I/O
// - index 2 primary I/O task file decode
// - index 3 secondary I/O task file decode
// - status register layout, D7/D1 read-only
// - changed flag; drives status pin low in I/O mode only
// - status enable 0 holds pin high
// - eight-bit request stored, no effect
// - power-down bit changes mode, ready busy
// - idle auto power-down, wake on command
// - interrupt pending mirrors request, disable gates
// - pin replacement register read layout
// - ready toggle sets ready-change flag
// - write-protect toggle sets its change flag
// - ready bit mirrors ready; mask write
// - write-protect bit reads 0; mask write
// - masked write of changed flags
// - socket register drive number at D4
module ccr_regs
   import ccr_pkg::*;
#(
   parameter int SETTLE_CYCLES = CCR_PWR_SETTLE_CYCLES
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // card pins from host
   input  wire ccr_bus_t    host_bus,
   input  wire logic [7:0]  host_wdata,
   input  wire logic        hw_reset_pin,
   // data bus, eight data outputs and one active-low output enable shared by all pins
   output logic [7:0]       data_out,
   output logic             data_oe_n,
   // status change pin, active low level
   output logic             status_change_pin_n,
   // card core side
   input  wire logic        core_ready,
   input  wire logic        core_irq,
   input  wire logic        interrupt_disable_bit,
   input  wire logic        core_idle,
   input  wire logic        core_command,
   input  wire logic [10:0] io_addr,
   output logic             card_reset,
   output logic             level_interrupt_select,
   output logic [5:0]       config_index,
   output logic             map_memory,
   output logic             map_io,
   output logic             task_file_hit,
   output logic             power_saving,
   output logic             ready_state,
   output logic             drive_number
);

   // ---------------------------------------------
   // reset release and pin synchronisers
   // ---------------------------------------------
   logic       rst_s1;
   logic       rst_n;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n  <= rst_s1;
      end
   end

   ccr_bus_t   bus_s1;
   ccr_bus_t   bus_s2;
   logic [7:0] wd_s1;
   logic [7:0] wd_s2;
   logic       hrst_s1;
   logic       hrst_s2;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_s1  <= '1;
         bus_s2  <= '1;
         wd_s1   <= 8'h00;
         wd_s2   <= 8'h00;
         hrst_s1 <= 1'b0;
         hrst_s2 <= 1'b0;
      end else begin
         bus_s1  <= host_bus;
         bus_s2  <= bus_s1;
         wd_s1   <= host_wdata;
         wd_s2   <= wd_s1;
         hrst_s1 <= hw_reset_pin;
         hrst_s2 <= hrst_s1;
      end
   end

   // ---------------------------------------------
   // attribute decode
   // ---------------------------------------------
   // a write acts once, on the falling edge of the synchronised write strobe
   logic       we_prev;
   logic       cfg_sel;
   logic       wr_pulse;
   logic [1:0] reg_sel;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) we_prev <= 1'b1;
      else        we_prev <= bus_s2.we_n;
   end

   // odd addresses and CIS writes fall out here
   assign cfg_sel = !bus_s2.reg_n && !bus_s2.ce1_n && !bus_s2.addr[10] && bus_s2.addr[9]
                    && !bus_s2.addr[0] && (bus_s2.addr[8:3] == CCR_BASE_ADDR[8:3]);
   assign wr_pulse = cfg_sel && !bus_s2.we_n && we_prev && bus_s2.oe_n;
   assign reg_sel  = bus_s2.addr[2:1];

   logic wr_opt;
   logic wr_sts;
   logic wr_pin;
   logic wr_sck;
   assign wr_opt = wr_pulse && (reg_sel == CCR_OPTION_ADDR[2:1]);
   assign wr_sts = wr_pulse && (reg_sel == CCR_STATUS_ADDR[2:1]);
   assign wr_pin = wr_pulse && (reg_sel == CCR_PINREP_ADDR[2:1]);
   assign wr_sck = wr_pulse && (reg_sel == CCR_SOCKET_ADDR[2:1]);

   // ---------------------------------------------
   // option register
   // ---------------------------------------------
   logic [7:0] opt;
   logic       hard_rst;
   assign hard_rst = hrst_s2;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)        opt <= CCR_OPTION_RESET;
      else if (hard_rst) opt <= CCR_OPTION_RESET;
      else if (wr_opt)   opt <= wd_s2;
   end

   logic soft_reset_bit;
   assign soft_reset_bit = opt[CCR_OPT_SOFT_RST_BIT];

   // ---------------------------------------------
   // status, socket registers
   // ---------------------------------------------
   logic status_change_enable;
   logic io8;
   logic pwrdn;
   logic sck_drive;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_change_enable <= CCR_STATUS_RESET[CCR_STS_CHG_EN_BIT];
         io8                  <= CCR_STATUS_RESET[CCR_STS_IO8_BIT];
         pwrdn                <= CCR_STATUS_RESET[CCR_STS_PWRDN_BIT];
      end else if (hard_rst || soft_reset_bit) begin
         status_change_enable <= CCR_STATUS_RESET[CCR_STS_CHG_EN_BIT];
         io8                  <= CCR_STATUS_RESET[CCR_STS_IO8_BIT];
         pwrdn                <= CCR_STATUS_RESET[CCR_STS_PWRDN_BIT];
      end else if (wr_sts) begin
         status_change_enable <= wd_s2[CCR_STS_CHG_EN_BIT];
         io8                  <= wd_s2[CCR_STS_IO8_BIT];
         pwrdn                <= wd_s2[CCR_STS_PWRDN_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)                          sck_drive <= CCR_SOCKET_RESET[CCR_SCK_DRIVE_BIT];
      else if (hard_rst || soft_reset_bit) sck_drive <= CCR_SOCKET_RESET[CCR_SCK_DRIVE_BIT];
      else if (wr_sck)                     sck_drive <= wd_s2[CCR_SCK_DRIVE_BIT];
   end

   // ---------------------------------------------
   // mapping mode
   // ---------------------------------------------
   ccr_map_t map_mode;
   always_comb begin
      case (opt[5:0])
         CCR_IDX_MEMORY:    map_mode = CCR_MAP_MEMORY;
         CCR_IDX_CONTIG,
         CCR_IDX_PRIMARY,
         CCR_IDX_SECONDARY: map_mode = CCR_MAP_IO;
         default:           map_mode = CCR_MAP_NONE;
      endcase
   end

   logic tf_hit;
   always_comb begin
      case (opt[5:0])
         CCR_IDX_MEMORY:    tf_hit = (io_addr[10:4] == 7'h00) || (io_addr[10] == CCR_MIRROR_ADDR[10]);
         CCR_IDX_CONTIG:    tf_hit = 1'b1;
         CCR_IDX_PRIMARY:   tf_hit = (io_addr[9:3] == CCR_PRI_BLK_ADDR[9:3])
                                     || (io_addr[9:1] == CCR_PRI_CTL_ADDR[9:1]);
         CCR_IDX_SECONDARY: tf_hit = (io_addr[9:3] == CCR_SEC_BLK_ADDR[9:3])
                                     || (io_addr[9:1] == CCR_SEC_CTL_ADDR[9:1]);
         default:           tf_hit = 1'b0;
      endcase
   end

   // ---------------------------------------------
   // power state machine
   // ---------------------------------------------
   // a host power-down change wins over the idle/command path, and idle/command is ignored while moving
   ccr_pwr_t pwr_state;
   logic     pwrdn_prev;
   logic     pwr_target;
   logic [7:0] settle_cnt;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwr_state  <= CCR_PWR_ACTIVE;
         pwrdn_prev <= 1'b0;
         pwr_target <= 1'b0;
         settle_cnt <= 8'h00;
      end else begin
         pwrdn_prev <= pwrdn;
         case (pwr_state)
            CCR_PWR_ACTIVE: begin
               if (pwrdn != pwrdn_prev || (core_idle && !core_command)) begin
                  pwr_state  <= CCR_PWR_MOVING;
                  pwr_target <= (pwrdn != pwrdn_prev) ? pwrdn : 1'b1;
                  settle_cnt <= 8'(SETTLE_CYCLES - 1);
               end
            end
            CCR_PWR_SAVING: begin
               if (pwrdn != pwrdn_prev || core_command) begin
                  pwr_state  <= CCR_PWR_MOVING;
                  pwr_target <= (pwrdn != pwrdn_prev) ? pwrdn : 1'b0;
                  settle_cnt <= 8'(SETTLE_CYCLES - 1);
               end
            end
            CCR_PWR_MOVING: begin
               if (pwrdn != pwrdn_prev) begin
                  pwr_target <= pwrdn;
                  settle_cnt <= 8'(SETTLE_CYCLES - 1);
               end else if (settle_cnt == 8'h00) begin
                  pwr_state <= pwr_target ? CCR_PWR_SAVING : CCR_PWR_ACTIVE;
               end else begin
                  settle_cnt <= settle_cnt - 8'h01;
               end
            end
            default: pwr_state <= CCR_PWR_ACTIVE;
         endcase
      end
   end

   // ---------------------------------------------
   // pin replacement register
   // ---------------------------------------------
   logic rdy_int;
   logic rdy_prev;
   logic crdy;
   logic cwp;
   logic wp_state;
   logic wp_prev;
   assign wp_state = 1'b0;
   assign rdy_int  = core_ready && (pwr_state != CCR_PWR_MOVING) && !soft_reset_bit && !hard_rst;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_prev <= 1'b0;
         wp_prev  <= 1'b0;
      end else begin
         rdy_prev <= rdy_int;
         wp_prev  <= wp_state;
      end
   end

   // a toggle in the same cycle as a host write wins over the written value
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         crdy <= 1'b0;
         cwp  <= 1'b0;
      end else begin
         if (rdy_int != rdy_prev) crdy <= 1'b1;
         else if (wr_pin && wd_s2[CCR_PIN_RRDY_BIT]) crdy <= wd_s2[CCR_PIN_CRDY_BIT];
         if (wp_state != wp_prev) cwp <= 1'b1;
         else if (wr_pin && wd_s2[CCR_PIN_WP_BIT]) cwp <= wd_s2[CCR_PIN_CWP_BIT];
      end
   end

   // ---------------------------------------------
   // read data and pins
   // ---------------------------------------------
   logic       changed;
   logic       int_pend;
   logic [7:0] next_rdata;
   assign changed  = crdy || cwp;
   assign int_pend = core_irq && !interrupt_disable_bit;

   always_comb begin
      next_rdata = 8'h00;
      case (reg_sel)
         CCR_OPTION_ADDR[2:1]: next_rdata = opt;
         CCR_STATUS_ADDR[2:1]: begin
            next_rdata[CCR_STS_CHANGED_BIT] = changed;
            next_rdata[CCR_STS_CHG_EN_BIT]  = status_change_enable;
            next_rdata[CCR_STS_IO8_BIT]     = io8;
            next_rdata[CCR_STS_PWRDN_BIT]   = pwrdn;
            next_rdata[CCR_STS_INT_BIT]     = int_pend;
         end
         CCR_PINREP_ADDR[2:1]: begin
            next_rdata = CCR_PINREP_FIXED;
            next_rdata[CCR_PIN_CRDY_BIT] = crdy;
            next_rdata[CCR_PIN_CWP_BIT]  = cwp;
            next_rdata[CCR_PIN_RRDY_BIT] = rdy_int;
            next_rdata[CCR_PIN_WP_BIT]   = wp_state;
         end
         default: next_rdata[CCR_SCK_DRIVE_BIT] = sck_drive;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out               <= 8'h00;
         data_oe_n              <= 1'b1;
         status_change_pin_n    <= 1'b1;
         card_reset             <= 1'b1;
         level_interrupt_select <= 1'b0;
         config_index           <= 6'h00;
         map_memory             <= 1'b0;
         map_io                 <= 1'b0;
         task_file_hit          <= 1'b0;
         power_saving           <= 1'b0;
         ready_state            <= 1'b0;
         drive_number           <= 1'b0;
      end else begin
         data_out               <= next_rdata;
         data_oe_n              <= !(cfg_sel && !bus_s2.oe_n && bus_s2.we_n);
         status_change_pin_n    <= !(map_mode == CCR_MAP_IO && status_change_enable && changed);
         card_reset             <= hard_rst || soft_reset_bit;
         level_interrupt_select <= opt[CCR_OPT_LEVIRQ_BIT];
         config_index           <= opt[5:0];
         map_memory             <= (map_mode == CCR_MAP_MEMORY) && !soft_reset_bit;
         map_io                 <= (map_mode == CCR_MAP_IO) && !soft_reset_bit;
         task_file_hit          <= tf_hit && !soft_reset_bit;
         power_saving           <= (pwr_state == CCR_PWR_SAVING);
         ready_state            <= rdy_int;
         drive_number           <= sck_drive;
      end
   end

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   // the hardware reset pin is the one legal way to change the option without a bus write
   chk_odd_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ((bus_s2.addr[0] || bus_s2.reg_n) && !hard_rst) |=> $stable(opt))
      else $error("odd or common access changed option");
   chk_cis_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!bus_s2.reg_n && !bus_s2.addr[9] && !hard_rst) |=> $stable(opt))
      else $error("write outside config window changed option");
   chk_status_pin: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (map_mode == CCR_MAP_IO && status_change_enable && changed && $stable(opt)) |=> !status_change_pin_n)
      else $error("status pin not driven low");
   chk_chg_en_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !status_change_enable |=> status_change_pin_n) else $error("status pin low while disabled");
   chk_hw_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hard_rst |=> opt == CCR_OPTION_RESET) else $error("hardware reset left option set");
   chk_soft_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      soft_reset_bit |=> card_reset && !map_io && !map_memory) else $error("soft reset not holding card");
   chk_rdy_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rdy_int != rdy_prev) |=> crdy) else $error("ready toggle missed");
   chk_mask_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_pin && !wd_s2[CCR_PIN_RRDY_BIT] && rdy_int == rdy_prev) |=> $stable(crdy))
      else $error("masked ready flag changed");
   chk_pwr_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pwrdn != pwrdn_prev) |=> !rdy_int) else $error("ready not busy on power change");
   chk_int_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (interrupt_disable_bit && reg_sel == CCR_STATUS_ADDR[2:1]) |=> !data_out[CCR_STS_INT_BIT])
      else $error("interrupt pending shown while disabled");

endmodule // ccr_regs

// *** ccr_host_model.sv ***
// host socket model that runs byte cycles on the attribute bus of the card
`timescale 1ns/100ps
module ccr_host_model
   import ccr_pkg::*;
(
   // clock
   input  wire logic       sys_clk,
   // card pins
   output ccr_bus_t        host_bus,
   output logic [7:0]      host_wdata,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n,
   // captured read result, one cycle wide
   output logic            rd_valid,
   output logic [8:0]      rd_result
);
   initial begin
      host_bus   = '{reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 11'h000};
      host_wdata = 8'h00;
      rd_valid   = 1'b0;
      rd_result  = 9'h000;
   end

   // ---------------------------------------------
   // bus cycles
   // ---------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // reserved places are written only when a scenario asks for a refusal
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      host_bus.addr  = a;
      host_bus.reg_n = 1'b0;
      host_bus.ce1_n = 1'b0;
      host_wdata     = d;
      cyc(2);
      host_bus.we_n = 1'b0;
      cyc(6);
      host_bus.we_n = 1'b1;
      cyc(2);
      host_bus.reg_n = 1'b1;
      host_bus.ce1_n = 1'b1;
      // released lines must not keep the old value, or a late sample would still match
      host_bus.addr = ~a;
      host_wdata    = ~d;
      cyc(4);
   endtask

   task automatic rd(input logic [10:0] a);
      host_bus.addr  = a;
      host_bus.reg_n = 1'b0;
      host_bus.ce1_n = 1'b0;
      cyc(2);
      host_bus.oe_n = 1'b0;
      cyc(6);
      rd_result     = {data_oe_n, data_out};
      rd_valid      = 1'b1;
      host_bus.oe_n = 1'b1;
      cyc(1);
      rd_valid       = 1'b0;
      host_bus.reg_n = 1'b1;
      host_bus.ce1_n = 1'b1;
      host_bus.addr  = ~a;
      cyc(4);
   endtask
endmodule // ccr_host_model

// *** ccr_regs_tb.sv ***
// self-checking testbench of the card configuration register bank
`timescale 1ns/100ps
module ccr_regs_tb
   import ccr_pkg::*;
();
   typedef struct packed {
      logic [8:0] val;
      logic [8:0] mask;
   } ccr_note_t;

   ccr_bus_t    host_bus;
   logic [7:0]  host_wdata, data_out, d;
   logic [10:0] io_addr;
   logic [5:0]  config_index;
   logic [8:0]  rd_result;
   logic        sys_clk, resetn, data_oe_n, status_change_pin_n, hw_reset_pin, rd_valid, lev;
   logic        core_ready, core_irq, interrupt_disable_bit, core_idle, core_command, card_reset;
   logic        level_interrupt_select, map_memory, map_io, task_file_hit, power_saving;
   logic        ready_state, drive_number;
   ccr_note_t   exp_q[$];
   ccr_note_t   e;
   int          failures = 0;
   int          n_checks = 0;
   int          seed = 95386;
   logic [10:0] hit_a[4] = '{11'h405, 11'h1A3, 11'h1F0, 11'h170};
   logic [10:0] miss_a[4] = '{11'h1F0, 11'h1F0, 11'h170, 11'h1F0};

   ccr_regs #(.SETTLE_CYCLES(4)) i_ccr_regs (
      .sys_clk(sys_clk), .resetn(resetn), .host_bus(host_bus), .host_wdata(host_wdata),
      .hw_reset_pin(hw_reset_pin), .data_out(data_out), .data_oe_n(data_oe_n),
      .status_change_pin_n(status_change_pin_n), .core_ready(core_ready), .core_irq(core_irq),
      .interrupt_disable_bit(interrupt_disable_bit), .core_idle(core_idle),
      .core_command(core_command), .io_addr(io_addr), .card_reset(card_reset),
      .level_interrupt_select(level_interrupt_select), .config_index(config_index),
      .map_memory(map_memory), .map_io(map_io), .task_file_hit(task_file_hit),
      .power_saving(power_saving), .ready_state(ready_state), .drive_number(drive_number));

   ccr_host_model i_ccr_host_model (
      .sys_clk(sys_clk), .host_bus(host_bus), .host_wdata(host_wdata), .data_out(data_out),
      .data_oe_n(data_oe_n), .rd_valid(rd_valid), .rd_result(rd_result));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ---------------------------------------------
   // checking
   // ---------------------------------------------
   task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      if (exp_q.size() != 0) failures++;
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cyc(input int n);
      i_ccr_host_model.cyc(n);
   endtask

   // refused reads are noted with only the enable bit compared
   task automatic rdx(input logic [10:0] a, input logic [8:0] v, input logic [8:0] m = 9'h1FF);
      exp_q.push_back('{val: v, mask: m});
      i_ccr_host_model.rd(a);
   endtask

   task automatic wrx(input logic [10:0] a, input logic [7:0] v);
      i_ccr_host_model.wr(a, v);
   endtask

   task automatic wait_pwr(input logic v);
      for (int k = 0; k < 64 && power_saving !== v; k++) cyc(1);
      cmp(9'(power_saving), 9'(v));
   endtask

   always @(posedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) cmp(rd_result, 9'h1FF);
         else begin
            e = exp_q.pop_front();
            cmp(rd_result & e.mask, e.val & e.mask);
         end
      end
   end

   initial begin
      #200000;
      failures++;
      test_done();
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      {resetn, hw_reset_pin, core_ready, core_irq, interrupt_disable_bit, core_idle, core_command} = 7'h00;
      io_addr = 11'h000;
      repeat (3) @(posedge sys_clk);
      #1 resetn = 1'b1;
      cyc(8);
      rdx(CCR_OPTION_ADDR, 9'(CCR_OPTION_RESET));
      rdx(CCR_STATUS_ADDR, 9'(CCR_STATUS_RESET));
      rdx(CCR_PINREP_ADDR, 9'(CCR_PINREP_FIXED));
      rdx(CCR_SOCKET_ADDR, 9'(CCR_SOCKET_RESET));
      for (int k = 0; k < 4; k++) begin
         lev = 1'($random(seed));
         wrx(CCR_OPTION_ADDR, {1'b0, lev, 6'(k)});
         rdx(CCR_OPTION_ADDR, {2'b00, lev, 6'(k)});
         cmp(9'(level_interrupt_select), 9'(lev));
         cmp(9'(config_index), 9'(k));
         cmp(9'({map_memory, map_io}), (k == 0) ? 9'h002 : 9'h001);
         io_addr = hit_a[k];
         cyc(3);
         cmp(9'(task_file_hit), 9'h001);
         io_addr = miss_a[k];
         cyc(3);
         if (k != 1) cmp(9'(task_file_hit), 9'h000);
      end
      wrx(CCR_OPTION_ADDR, 8'h05);
      cmp(9'({map_memory, map_io}), 9'h000);
      wrx(CCR_OPTION_ADDR, 8'h01);
      wrx(11'h201, 8'h3F);
      wrx(11'h000, 8'h3F);
      rdx(CCR_OPTION_ADDR, 9'h001);
      rdx(11'h203, 9'h100, 9'h100);
      core_irq = 1'b1;
      rdx(CCR_STATUS_ADDR, 9'h002);
      interrupt_disable_bit = 1'b1;
      rdx(CCR_STATUS_ADDR, 9'h000);
      {core_irq, interrupt_disable_bit} = 2'b00;
      wrx(CCR_STATUS_ADDR, 8'h40);
      core_ready = 1'b1;
      cyc(4);
      cmp(9'(ready_state), 9'h001);
      rdx(CCR_PINREP_ADDR, 9'h02E);
      rdx(CCR_STATUS_ADDR, 9'h0C0);
      cmp(9'(status_change_pin_n), 9'h000);
      wrx(CCR_STATUS_ADDR, 8'h00);
      cmp(9'(status_change_pin_n), 9'h001);
      wrx(CCR_PINREP_ADDR, 8'h00);
      rdx(CCR_PINREP_ADDR, 9'h02E);
      wrx(CCR_PINREP_ADDR, 8'h02);
      rdx(CCR_PINREP_ADDR, 9'h00E);
      wrx(CCR_PINREP_ADDR, 8'h11);
      rdx(CCR_PINREP_ADDR, 9'h01E);
      rdx(CCR_STATUS_ADDR, 9'h080);
      wrx(CCR_PINREP_ADDR, 8'h01);
      wrx(CCR_STATUS_ADDR, 8'hA3);
      rdx(CCR_STATUS_ADDR, 9'h020);
      wrx(CCR_STATUS_ADDR, 8'h04);
      wait_pwr(1'b1);
      rdx(CCR_PINREP_ADDR, 9'h02E);
      wrx(CCR_PINREP_ADDR, 8'h02);
      wrx(CCR_STATUS_ADDR, 8'h00);
      wait_pwr(1'b0);
      core_idle = 1'b1;
      wait_pwr(1'b1);
      {core_idle, core_command} = 2'b01;
      wait_pwr(1'b0);
      core_command = 1'b0;
      wrx(CCR_OPTION_ADDR, 8'h81);
      cmp(9'(card_reset), 9'h001);
      rdx(CCR_OPTION_ADDR, 9'h081);
      wrx(CCR_OPTION_ADDR, 8'h00);
      cmp(9'(card_reset), 9'h000);
      wrx(CCR_OPTION_ADDR, 8'h41);
      hw_reset_pin = 1'b1;
      cyc(6);
      cmp(9'(card_reset), 9'h001);
      cmp(9'(level_interrupt_select), 9'h000);
      hw_reset_pin = 1'b0;
      cyc(6);
      rdx(CCR_OPTION_ADDR, 9'h000);
      d = 8'($random(seed)) & 8'h7F;
      wrx(CCR_SOCKET_ADDR, d);
      rdx(CCR_SOCKET_ADDR, 9'(d & 8'h10));
      cmp(9'(drive_number), 9'(d[4]));
      cyc(2);
      test_done();
   end
endmodule // ccr_regs_tb
